// ===== logic/cmd_select_pkg.sv
// package for the drive command and speed reference source selection block
// shared by the top module and the speed reference mixer
package cmd_select_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] run_source_offset   = 8'h00;
    localparam logic [7:0] speed_source_offset = 8'h04;
    localparam logic [7:0] control_mode_offset = 8'h08;
    localparam logic [7:0] accel_time_offset   = 8'h0C;
    localparam logic [7:0] decel_time_offset   = 8'h10;
    localparam logic [7:0] panel_speed_offset  = 8'h14;
    localparam logic [7:0] status_offset       = 8'h18;
    localparam logic [7:0] speed_out_offset    = 8'h1C;
    localparam logic [7:0] updown_step_offset  = 8'h20;
    // reset values
    localparam logic       run_source_reset    = 1'b0;
    localparam logic [3:0] speed_source_reset  = 4'h1;
    localparam logic [1:0] control_mode_reset  = 2'h1;
    localparam logic [15:0] accel_time_reset   = 16'h0064;
    localparam logic [15:0] decel_time_reset   = 16'h0064;
    localparam logic [15:0] updown_step_reset  = 16'h0001;
    // status field positions
    localparam int status_running_bit  = 0;
    localparam int status_reverse_bit  = 1;
    localparam int status_fwd_led_bit  = 2;
    localparam int status_edit_bit     = 3;
    localparam int status_pi2_bit      = 4;
    // speed reference source codes
    typedef enum logic [3:0] {
        src_panel_keys = 4'h0,
        src_panel_pot  = 4'h1,
        src_analog_one = 4'h2,
        src_analog_two = 4'h3,
        src_analog_sum = 4'h4,
        src_analog_max = 4'h5,
        src_analog_min = 4'h6,
        src_pid        = 4'h7,
        src_updown     = 4'h8
    } speed_source_t;
    // motor control method codes
    typedef enum logic [1:0] {
        mode_autotune     = 2'h0,
        mode_volt_freq    = 2'h1,
        mode_flux_vector  = 2'h2,
        mode_volt_vector  = 2'h3
    } control_mode_t;
    // secondary digital input function code that selects the second speed pi group when the control mode is flux vector
    localparam logic [3:0] di_func_second_pi = 4'hB;
    // write response code
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ===== logic/speed_mix_if.sv
// interface carrying analog samples and the mixed reference between top and mixer
// assumes one clock domain; all signals synchronous to aclk
`timescale 1ns/10ps
interface speed_mix_if #(parameter int width = 16);
    import cmd_select_pkg::*;
    speed_source_t          source;
    logic [width-1:0]       analog_one;
    logic [width-1:0]       analog_two;
    logic [width-1:0]       pid_value;
    logic [width-1:0]       pot_value;
    logic [width-1:0]       panel_value;
    logic [width-1:0]       updown_value;
    logic [width-1:0]       mixed;
    modport top (output source, analog_one, analog_two, pid_value, pot_value,
                 panel_value, updown_value, input mixed);
    modport mixer (input source, analog_one, analog_two, pid_value, pot_value,
                   panel_value, updown_value, output mixed);
endinterface

// ===== logic/speed_mixer.sv
// combinational speed reference mixer: picks or combines sources per selection
// assumes both analog inputs are sampled together in the same cycle by the caller
`timescale 1ns/10ps
module speed_mixer
    import cmd_select_pkg::*;
#(
    parameter int width = 16
) (
    // source selection and samples
    speed_mix_if.mixer mix,
    // pid option present on this variant
    input wire logic   pid_present
);
    logic [width:0] sum_wide;

    // sum saturates at full scale instead of wrapping
    always_comb begin
        sum_wide = {1'b0, mix.analog_one} + {1'b0, mix.analog_two};
        unique case (mix.source)
            src_panel_keys: mix.mixed = mix.panel_value;
            src_panel_pot:  mix.mixed = mix.pot_value;
            src_analog_one: mix.mixed = mix.analog_one;
            src_analog_two: mix.mixed = mix.analog_two;
            src_analog_sum: mix.mixed = sum_wide[width] ? {width{1'b1}} : sum_wide[width-1:0];
            src_analog_max: mix.mixed = (mix.analog_one > mix.analog_two) ?
                                        mix.analog_one : mix.analog_two;
            src_analog_min: mix.mixed = (mix.analog_one < mix.analog_two) ?
                                        mix.analog_one : mix.analog_two;
            src_pid:        mix.mixed = pid_present ? mix.pid_value : '0;
            src_updown:     mix.mixed = mix.updown_value;
            default:        mix.mixed = '0;
        endcase
    end
endmodule

// ===== logic/drive_command_source_select.sv
// drive command and speed reference source selection with AXI4-Lite registers
// assumes panel keys and terminal inputs are synchronous, debounced levels
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module drive_command_source_select
    import cmd_select_pkg::*;
#(
    parameter int width = 16
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // axi4-lite write address, data and response
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // operator panel
    input  wire logic             forward_run_key,
    input  wire logic             reverse_run_key,
    input  wire logic             stop_key,
    input  wire logic             up_key,
    input  wire logic             down_key,
    input  wire logic             frequency_prompt_shown,
    input  wire logic [width-1:0] panel_pot,
    // digital input terminals
    input  wire logic             forward_run_input,
    input  wire logic             reverse_run_input,
    input  wire logic             speed_up_input,
    input  wire logic             speed_down_input,
    input  wire logic             second_pi_input,
    input  wire logic [3:0]       second_pi_function,
    // analog and pid samples
    input  wire logic [width-1:0] analog_input_one,
    input  wire logic [width-1:0] analog_input_two,
    input  wire logic [width-1:0] pid_output,
    input  wire logic             pid_present,
    // drive outputs
    output logic                  run_enable,
    output logic                  reverse_dir,
    output logic                  forward_led,
    output logic [width-1:0]      speed_reference,
    output logic [1:0]            control_mode,
    output logic                  second_pi_select
);
    // whole module state
    typedef struct packed {
        logic             aw_hold;
        logic [7:0]       aw_addr;
        logic             w_hold;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic             run_source_select;
        speed_source_t    speed_source_select;
        control_mode_t    motor_control_method_select;
        logic [15:0]      main_accel_time;
        logic [15:0]      main_decel_time;
        logic [15:0]      updown_step;
        logic [width-1:0] panel_speed;
        logic [width-1:0] updown_speed;
        logic             running;
        logic             reverse;
        logic             fwd_led;
        logic             edit_mode;
        logic             up_key_last;
        logic             pi2;
        logic [width-1:0] speed_ref;
    } state_t;

    state_t state;
    state_t next_state;
    speed_mix_if #(.width(width)) mix ();

    // mixer inputs: both analog inputs taken in the same cycle
    assign mix.source       = state.speed_source_select;
    assign mix.analog_one   = analog_input_one;
    assign mix.analog_two   = analog_input_two;
    assign mix.pid_value    = pid_output;
    assign mix.pot_value    = panel_pot;
    assign mix.panel_value  = state.panel_speed;
    assign mix.updown_value = state.updown_speed;

    speed_mixer #(.width(width)) u_mixer (
        .mix         (mix.mixer),
        .pid_present (pid_present)
    );

    // apply a byte-strobed write to a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // next state: bus slave, command arbitration, reference update
    always_comb begin
        logic [31:0] word;
        logic [width:0] step_wide;
        word = '0;
        step_wide = '0;
        next_state = state;
        // accept address and data in either order
        if (s_axi_awvalid && !state.aw_hold) begin
            next_state.aw_hold = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_hold) begin
            next_state.w_hold = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        // perform write once both halves are held and no response pending
        if (state.aw_hold && state.w_hold && !state.bvalid) begin
            next_state.aw_hold = 1'b0;
            next_state.w_hold  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = resp_okay;
            unique case (state.aw_addr)
                run_source_offset: begin
                    word = merge({31'h0, state.run_source_select}, state.w_data, state.w_strb);
                    next_state.run_source_select = word[0];
                end
                speed_source_offset: begin
                    word = merge({28'h0, state.speed_source_select}, state.w_data,
                                 state.w_strb);
                    if (word[3:0] <= 4'h8) begin
                        next_state.speed_source_select = speed_source_t'(word[3:0]);
                    end else begin
                        next_state.bresp = resp_slverr;
                    end
                end
                control_mode_offset: begin
                    word = merge({30'h0, state.motor_control_method_select}, state.w_data,
                                 state.w_strb);
                    next_state.motor_control_method_select = control_mode_t'(word[1:0]);
                end
                accel_time_offset: begin
                    word = merge({16'h0, state.main_accel_time}, state.w_data, state.w_strb);
                    next_state.main_accel_time = word[15:0];
                end
                decel_time_offset: begin
                    word = merge({16'h0, state.main_decel_time}, state.w_data, state.w_strb);
                    next_state.main_decel_time = word[15:0];
                end
                updown_step_offset: begin
                    word = merge({16'h0, state.updown_step}, state.w_data, state.w_strb);
                    next_state.updown_step = word[15:0];
                end
                panel_speed_offset: begin
                    word = merge({{(32-width){1'b0}}, state.panel_speed}, state.w_data,
                                 state.w_strb);
                    next_state.panel_speed = word[width-1:0];
                end
                default: next_state.bresp = resp_slverr;
            endcase
        end
        // reads answer one cycle after the address is taken
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !state.rvalid) begin
            next_state.rvalid = 1'b1;
            unique case (s_axi_araddr)
                run_source_offset:   next_state.rdata = {31'h0, state.run_source_select};
                speed_source_offset: next_state.rdata = {28'h0, state.speed_source_select};
                control_mode_offset: next_state.rdata = {30'h0, state.motor_control_method_select};
                accel_time_offset:   next_state.rdata = {16'h0, state.main_accel_time};
                decel_time_offset:   next_state.rdata = {16'h0, state.main_decel_time};
                updown_step_offset:  next_state.rdata = {16'h0, state.updown_step};
                panel_speed_offset:  next_state.rdata = {{(32-width){1'b0}}, state.panel_speed};
                speed_out_offset:    next_state.rdata = {{(32-width){1'b0}}, state.speed_ref};
                status_offset: begin
                    next_state.rdata = '0;
                    next_state.rdata[status_running_bit] = state.running;
                    next_state.rdata[status_reverse_bit] = state.reverse;
                    next_state.rdata[status_fwd_led_bit] = state.fwd_led;
                    next_state.rdata[status_edit_bit]    = state.edit_mode;
                    next_state.rdata[status_pi2_bit]     = state.pi2;
                end
                default:             next_state.rdata = '0;
            endcase
        end

        if (state.run_source_select == 1'b0) begin
            if (forward_run_key && frequency_prompt_shown) begin
                next_state.running = 1'b1;
                next_state.reverse = 1'b0;
            end else if (reverse_run_key && frequency_prompt_shown) begin
                next_state.running = 1'b1;
                next_state.reverse = 1'b1;
            end
            if (stop_key) begin
                next_state.running = 1'b0;
            end
            next_state.fwd_led = next_state.running && !next_state.reverse;
        end else begin
            next_state.running = forward_run_input || reverse_run_input;
            next_state.reverse = !forward_run_input && reverse_run_input;
            next_state.fwd_led = forward_run_input;
        end

        next_state.up_key_last = up_key;
        if (state.speed_source_select != src_panel_keys || !state.running) begin
            next_state.edit_mode = 1'b0;
        end else if (up_key && !state.up_key_last) begin
            next_state.edit_mode = 1'b1;
        end
        if (state.edit_mode && up_key && !state.up_key_last) begin
            step_wide = {1'b0, state.panel_speed} + {{(width-15){1'b0}}, state.updown_step[14:0]};
            next_state.panel_speed = step_wide[width] ? {width{1'b1}} : step_wide[width-1:0];
        end else if (state.edit_mode && down_key) begin
            next_state.panel_speed = (state.panel_speed > width'(state.updown_step)) ?
                                     state.panel_speed - width'(state.updown_step) : '0;
        end

        if (state.speed_source_select == src_updown) begin
            if (speed_up_input && !speed_down_input) begin
                step_wide = {1'b0, state.updown_speed} + {{(width-15){1'b0}},
                            state.updown_step[14:0]};
                next_state.updown_speed = step_wide[width] ? {width{1'b1}} :
                                          step_wide[width-1:0];
            end else if (speed_down_input && !speed_up_input) begin
                next_state.updown_speed = (state.updown_speed > width'(state.updown_step)) ?
                                          state.updown_speed - width'(state.updown_step) : '0;
            end
        end

        next_state.pi2 = (state.motor_control_method_select == mode_flux_vector) &&
                         (second_pi_function == di_func_second_pi) && second_pi_input;

        next_state.speed_ref = mix.mixed;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.run_source_select <= run_source_reset;
            state.speed_source_select <= speed_source_t'(speed_source_reset);
            state.motor_control_method_select <= control_mode_t'(control_mode_reset);
            state.main_accel_time <= accel_time_reset;
            state.main_decel_time <= decel_time_reset;
            state.updown_step <= updown_step_reset;
        end else begin
            state <= next_state;
        end
    end

    // bus and drive outputs straight from state, except s_axi_rresp which is tied to okay
    assign s_axi_awready    = !state.aw_hold;
    assign s_axi_wready     = !state.w_hold;
    assign s_axi_bvalid     = state.bvalid;
    assign s_axi_bresp      = state.bresp;
    assign s_axi_arready    = !state.rvalid;
    assign s_axi_rvalid     = state.rvalid;
    assign s_axi_rdata      = state.rdata;
    assign s_axi_rresp      = resp_okay;
    assign run_enable       = state.running;
    assign reverse_dir      = state.reverse;
    assign forward_led      = state.fwd_led;
    assign speed_reference  = state.speed_ref;
    assign control_mode     = state.motor_control_method_select;
    assign second_pi_select = state.pi2;
endmodule

// ===== test/cmd_select_asserts.sv
// port checks for the command source selection block
// bound to the top module from tb; one clock aclk, sync reset aresetn
`timescale 1ns/10ps
module cmd_select_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus answers
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // drive side
    input wire logic        second_pi_input,
    input wire logic [3:0]  second_pi_function,
    input wire logic        run_enable,
    input wire logic [1:0]  control_mode,
    input wire logic        second_pi_select
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // answers hold until the master takes them
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");
    read_gate_a: assert property (s_axi_arready != s_axi_rvalid)
        else $error("read address ready wrong");
    reset_mode_a: assert property ($rose(aresetn) |-> control_mode == 2'h1 && !run_enable)
        else $error("reset values wrong");
    second_pi_on_a: assert property (second_pi_input && second_pi_function == 4'hB
        && control_mode == 2'h2 && $stable(control_mode) |=> second_pi_select)
        else $error("second pi group not selected");
    second_pi_off_a: assert property (!second_pi_input |=> !second_pi_select)
        else $error("second pi group held without input");
endmodule

// ===== test/panel_terminal_model.sv
// operator panel keys and terminal inputs seen by the selection block
// levels change just after a rising edge, like debounced switches
`timescale 1ns/10ps
module panel_terminal_model (
    // clock
    input wire logic  aclk,
    // keys: fwd rev stop up down prompt
    output logic [5:0] keys,
    // terminals: fwd rev up down second_pi
    output logic [4:0] terms
);
    initial begin
        keys = 6'h00;
        terms = 5'h00;
    end
    // panel key and terminal levels
    task automatic press(input logic [5:0] k);
        @(posedge aclk);
        keys <= k;
    endtask
    task automatic set_terms(input logic [4:0] t);
        @(posedge aclk);
        terms <= t;
    endtask
endmodule

// ===== test/tb.sv
// self-checking bench for the command source selection block
// drives the bus and analog samples; panel and terminals come from the model
`timescale 1ns/10ps
module tb;
    import cmd_select_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pid_present;
    logic run_enable, reverse_dir, forward_led, second_pi_select;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb, second_pi_function;
    logic [1:0] s_axi_bresp, s_axi_rresp, control_mode, r;
    logic [15:0] a1, a2, pot, pid, speed_reference;
    logic [5:0] keys;
    logic [4:0] terms;
    int n_mismatch = 0, cmp_count = 0;
    logic [7:0] ra [6] = '{run_source_offset, speed_source_offset, control_mode_offset,
                          accel_time_offset, decel_time_offset, updown_step_offset};
    logic [31:0] rv [6] = '{32'h0, 32'h1, 32'h1, 32'h64, 32'h64, 32'h1};
    logic [15:0] sx [8] = '{16'h0, 16'h0321, 16'h3000, 16'h1234, 16'h4234, 16'h3000,
                           16'h1234, 16'h0777};
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    panel_terminal_model i_panel (.aclk, .keys, .terms);
    drive_command_source_select i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .forward_run_key(keys[5]),
        .reverse_run_key(keys[4]), .stop_key(keys[3]), .up_key(keys[2]), .down_key(keys[1]),
        .frequency_prompt_shown(keys[0]), .panel_pot(pot), .forward_run_input(terms[4]),
        .reverse_run_input(terms[3]), .speed_up_input(terms[2]), .speed_down_input(terms[1]),
        .second_pi_input(terms[0]), .second_pi_function, .analog_input_one(a1),
        .analog_input_two(a2), .pid_output(pid), .pid_present, .run_enable, .reverse_dir,
        .forward_led, .speed_reference, .control_mode, .second_pi_select);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // write: offer both halves, drop each when taken, then wait for the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] b);
        logic aw, w;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        do begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !aw || s_axi_wvalid && !w);
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        b = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
        {a1, a2, pot, pid, pid_present, second_pi_function} = {16'h3000, 16'h1234, 16'h0456,
                                                              16'h0777, 1'b1, 4'h0};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle(1);
        chk(control_mode, 32'h1);
        chk(speed_reference, 32'h456);
        pot <= 16'h0321;
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], v);
            chk(v, rv[i]);
        end
        rd(8'h24, v);
        chk(v, 32'h0);
        wr(8'h24, 32'h5, r);
        chk(r, resp_slverr);
        wr(speed_source_offset, 32'h9, r);
        chk(r, resp_slverr);
        for (int s = 1; s < 8; s++) begin
            wr(speed_source_offset, s, r);
            settle(3);
            chk(speed_reference, sx[s]);
        end
        pid <= 16'h0888;
        settle(3);
        chk(speed_reference, 32'h888);
        pid_present <= 1'b0;
        settle(3);
        chk(speed_reference, 32'h0);
        wr(speed_source_offset, 32'h4, r);
        {a1, a2} <= {16'hF000, 16'h2000};
        settle(3);
        chk(speed_reference, 32'hFFFF);
        i_panel.set_terms(5'b10000);
        i_panel.press(6'b100000);
        settle(3);
        chk(run_enable, 32'h0);
        i_panel.press(6'b100001);
        settle(3);
        chk({run_enable, reverse_dir}, 32'h2);
        i_panel.press(6'b010001);
        settle(3);
        chk({run_enable, reverse_dir}, 32'h3);
        i_panel.press(6'b001001);
        settle(3);
        chk(run_enable, 32'h0);
        i_panel.press(6'b000000);
        wr(run_source_offset, 32'h1, r);
        settle(3);
        chk({run_enable, forward_led}, 32'h3);
        i_panel.set_terms(5'b00000);
        i_panel.press(6'b100001);
        settle(3);
        chk({run_enable, forward_led}, 32'h0);
        i_panel.set_terms(5'b01000);
        settle(3);
        chk({run_enable, reverse_dir}, 32'h3);
        i_panel.press(6'b000000);
        i_panel.set_terms(5'b10000);
        wr(panel_speed_offset, 32'h10, r);
        wr(speed_source_offset, 32'h0, r);
        i_panel.press(6'b000101);
        settle(3);
        rd(status_offset, v);
        chk(v[status_edit_bit], 32'h1);
        i_panel.press(6'b000001);
        i_panel.press(6'b000101);
        settle(3);
        chk(speed_reference, 32'h11);
        i_panel.press(6'b000011);
        settle(30);
        chk(speed_reference, 32'h0);
        wr(updown_step_offset, 32'h4, r);
        wr(speed_source_offset, 32'h8, r);
        i_panel.set_terms(5'b00010);
        settle(30);
        i_panel.set_terms(5'b00100);
        repeat (4) @(posedge aclk);
        i_panel.set_terms(5'b00000);
        settle(3);
        chk(speed_reference, 32'h14);
        for (int m = 0; m < 4; m++) begin
            wr(control_mode_offset, m, r);
            settle(3);
            chk(control_mode, m);
        end
        wr(control_mode_offset, 32'h2, r);
        second_pi_function <= di_func_second_pi;
        i_panel.set_terms(5'b00001);
        settle(3);
        chk(second_pi_select, 32'h1);
        second_pi_function <= 4'hA;
        settle(3);
        chk(second_pi_select, 32'h0);
        wr(accel_time_offset, 32'h13, r);
        rd(accel_time_offset, v);
        chk(v, 32'h13);
        s_axi_wstrb <= 4'h1;
        wr(decel_time_offset, 32'h1234, r);
        rd(decel_time_offset, v);
        chk(v, 32'h34);
        final_report();
    end
endmodule
bind drive_command_source_select cmd_select_checker i_chk (.aclk, .aresetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_axi_bvalid,
    .s_axi_bready, .second_pi_input, .second_pi_function, .run_enable, .control_mode,
    .second_pi_select);
